// >>> core/bm_pkg.sv
// Bank-1 special register map: offsets, field positions, reset values and carrier types.
// Assumes the processor core presents bank-local 7-bit addresses on the core clock.
package bm_pkg;

	// Printed byte offsets; decode compares the low seven bits
	localparam logic [7:0] OFS_INDIRECT = 8'h80;
	localparam logic [7:0] OFS_PC_LOW   = 8'h82;
	localparam logic [7:0] OFS_STATUS   = 8'h83;
	localparam logic [7:0] OFS_INTCTRL  = 8'h8b;
	localparam logic [7:0] OFS_RESET_CS = 8'h8e;

	// Bank select value that maps this bank
	localparam logic [1:0] BANK_ONE = 2'h1;

	// Plain storage registers, one index each
	localparam int N_SIMPLE    = 16;
	localparam int IX_OPTION   = 0;
	localparam int IX_DIR_A    = 1;
	localparam int IX_DIR_B    = 2;
	localparam int IX_DIR_C    = 3;
	localparam int IX_DIR_D    = 4;
	localparam int IX_DIR_E    = 5;
	localparam int IX_PERIPHERAL_IRQ_ENABLE_1     = 6;
	localparam int IX_PERIPHERAL_IRQ_ENABLE_2     = 7;
	localparam int IX_T2PER    = 8;
	localparam int IX_SSPADDR  = 9;
	localparam int IX_TXCTRL   = 10;
	localparam int IX_BAUD     = 11;
	localparam int IX_ANALOG   = 12;
	localparam int IX_PCHOLD   = 13;
	localparam int IX_POINTER  = 14;
	localparam int IX_SSPSTATE = 15;

	// Tables below list index 15 first, index 0 last
	localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_OFS = {
		8'h94, 8'h84, 8'h8a, 8'h9f, 8'h99, 8'h98, 8'h93, 8'h92,
		8'h8d, 8'h8c, 8'h89, 8'h88, 8'h87, 8'h86, 8'h85, 8'h81};
	// Writable bit positions; others read as zero or as live status
	localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_WMASK = {
		8'hc0, 8'hff, 8'h1f, 8'h07, 8'hff, 8'hf5, 8'hff, 8'hff,
		8'h01, 8'hff, 8'h17, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff};
	// Power-on and brown-out values (unknown bits chosen as zero)
	localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_POR = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
		8'h00, 8'h00, 8'h07, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff};
	// Values on the other resets
	localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_WARM = SIMPLE_POR;
	// Bits that keep their value across the other resets
	localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_KEEP = {
		8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Bits that always read as one; none in this bank
	localparam logic [N_SIMPLE-1:0][7:0] SIMPLE_ONES = '0;
	// Registers reached from every bank
	localparam logic [N_SIMPLE-1:0] SIMPLE_MIRROR = 16'h6000;

	// Status register fields
	localparam int ST_IRP = 7;
	localparam int ST_RP1 = 6;
	localparam int ST_RP0 = 5;
	localparam int ST_TO  = 4;
	localparam int ST_PD  = 3;
	localparam logic [7:0] STATUS_POR    = 8'h18;
	localparam logic [7:0] STATUS_WMASK  = 8'he7;
	localparam logic [7:0] STATUS_KEEP   = 8'h07;

	// Interrupt control fields
	localparam logic [7:0] INTCTRL_POR  = 8'h00;
	localparam logic [7:0] INTCTRL_KEEP = 8'h01;
	localparam int INTCTRL_FLAGS = 3;

	// Port E direction and slave status fields
	localparam int DE_IN_FULL  = 7;
	localparam int DE_OUT_FULL = 6;
	localparam int DE_OVERFLOW = 5;

	// Reset cause fields
	localparam int RC_POWER = 1;
	localparam int RC_BROWN = 0;

	// Other live status positions
	localparam int TX_SHIFT_EMPTY = 1;
	localparam int SSP_STATE_W    = 6;

	// Program counter
	localparam int PC_W      = 13;
	localparam int PC_HOLD_W = 5;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

	// Core access request, taken on a clock edge
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} bm_bus_req_t;

	// Live status and events from peripherals and core
	typedef struct packed {
		logic                   psp_in_full;
		logic                   psp_out_full;
		logic                   psp_overflow;
		logic [SSP_STATE_W-1:0] ssp_state;
		logic                   tx_shift_empty;
		logic [INTCTRL_FLAGS-1:0] intctrl_events;
	} bm_periph_t;

	// Configuration seen by the peripherals
	typedef struct packed {
		logic [N_SIMPLE-1:0][7:0] simple;
		logic [7:0]               status;
		logic [7:0]               intctrl;
		logic [1:0]               reset_cause;
	} bm_cfg_t;

endpackage : bm_pkg

// >>> core/bm_sync2.sv
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module bm_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	input  wire logic [WIDTH-1:0] rst_val,
	output var  logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta; // First stage, read only by the second

	// Reset loads ones so a released pin does not look asserted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

	logic unused_rst_val;
	assign unused_rst_val = ^rst_val;
endmodule : bm_sync2
`default_nettype wire

// >>> core/bm_field_reg.sv
// One storage register with distinct power-on and other-reset values.
// Assumes the warm reset request is synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module bm_field_reg #(
	parameter logic [7:0] POR_VAL  = 8'h00,
	parameter logic [7:0] WARM_VAL = 8'h00,
	parameter logic [7:0] KEEP     = 8'h00,
	parameter logic [7:0] WR_MASK  = 8'hff
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       warm,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] q
);
	// Bits outside the mask never store anything, so they read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= POR_VAL & WR_MASK;
		end else if (warm) begin
			q <= ((q & KEEP) | (WARM_VAL & ~KEEP)) & WR_MASK;
		end else if (we) begin
			q <= wdata & WR_MASK;
		end
	end
endmodule : bm_field_reg
`default_nettype wire

// >>> core/bm_bank1_regs.sv
// Bank-1 special register map with mirrored core registers and indirect window.
// Assumes a core on REF_CLK issuing one access per cycle and a data memory
// that answers IND_RDATA combinationally for the address on IND_ADDR.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Upper program counter has no location
// - Holding bits load counter top on update
// - Master clear and watchdog apply warm values
// - Core registers reachable from every bank
// - 28-pin omits port D/E, reads zero
// - Unimplemented locations and bits read zero
// - Unchanged bits keep, conditional bits follow cause
// - Always-one bits read one
module bm_bank1_regs #(
	parameter bit FORTY_PIN = 1'b1 // 0 selects the 28-pin variant
) (
	input  wire logic                   REF_CLK,
	input  wire logic                   NRST,
	input  wire bm_pkg::bm_bus_req_t    BUS_REQ,
	output var  logic [7:0]             RDATA,
	input  wire logic                   MASTER_CLEAR_PIN_N,
	input  wire logic                   WATCHDOG_RESET_SOURCE,
	input  wire logic                   BROWN_OUT_RESET,
	input  wire logic                   SLEEP_ENTER,
	input  wire logic                   WATCHDOG_CLEARED,
	input  wire logic                   PC_LOAD,
	input  wire logic [7:0]             PC_NEXT_LOW,
	output var  logic [bm_pkg::PC_W-1:0] PROGRAM_COUNTER,
	output var  logic [7:0]             IND_ADDR,
	input  wire logic [7:0]             IND_RDATA,
	output var  logic                   IND_WE,
	output var  logic [7:0]             IND_WDATA,
	input  wire bm_pkg::bm_periph_t     PERIPH,
	output var  bm_pkg::bm_cfg_t        CONFIG,
	output var  logic                   WARM_RESET
);

	// Synchronised master clear level
	logic                                   master_clear_n_sync;
	// Warm reset request this cycle
	logic                                   warm;
	// Bank one selected by the status bank bits
	logic                                   bank1;
	// Per-register decode and write strobes
	logic [bm_pkg::N_SIMPLE-1:0]            simple_hit;
	logic [bm_pkg::N_SIMPLE-1:0]            simple_we;
	// Stored values of the plain registers
	logic [bm_pkg::N_SIMPLE-1:0][7:0]       simple_q;
	// Live status overlaid on reads
	logic [bm_pkg::N_SIMPLE-1:0][7:0]       live_bits;
	// Special register decodes
	logic                                   hit_indirect;
	logic                                   hit_pc_low;
	logic                                   hit_status;
	logic                                   hit_intctrl;
	logic                                   hit_reset_cs;
	// Special storage
	logic [7:0]                             status;
	logic [7:0]                             intctrl;
	logic                                   power_flag;
	logic                                   brown_flag;
	logic                                   psp_overflow;
	logic [bm_pkg::PC_W-1:0]                pc;
	// Read data for this cycle
	logic [7:0]                             rd_mux;

	// Address match: mirrored registers ignore the bank bits
	function automatic logic bm_hit(input logic [6:0] a, input logic [7:0] ofs,
		input logic in_bank, input logic mirrored);
		bm_hit = (a == ofs[6:0]) && (in_bank || mirrored);
	endfunction : bm_hit

	// Variant check for the port D and E locations
	function automatic logic bm_present(input int idx);
		bm_present = FORTY_PIN || !(idx == bm_pkg::IX_DIR_D || idx == bm_pkg::IX_DIR_E);
	endfunction : bm_present

	// Pin crosses into the core clock before use
	bm_sync2 #(
		.WIDTH (1)
	) u_master_clear_pin_sync (
		.clk     (REF_CLK),
		.rst_n   (NRST),
		.d       (MASTER_CLEAR_PIN_N),
		.rst_val (1'b1),
		.q       (master_clear_n_sync)
	);

	// Held for as long as the pin is low
	assign warm  = !master_clear_n_sync || WATCHDOG_RESET_SOURCE;
	assign bank1 = ({status[bm_pkg::ST_RP1], status[bm_pkg::ST_RP0]} == bm_pkg::BANK_ONE);

	// Mirrored core registers decode in every bank
	always_comb begin
		hit_indirect = bm_hit(BUS_REQ.addr, bm_pkg::OFS_INDIRECT, bank1, 1'b1);
		hit_pc_low   = bm_hit(BUS_REQ.addr, bm_pkg::OFS_PC_LOW, bank1, 1'b1);
		hit_status   = bm_hit(BUS_REQ.addr, bm_pkg::OFS_STATUS, bank1, 1'b1);
		hit_intctrl  = bm_hit(BUS_REQ.addr, bm_pkg::OFS_INTCTRL, bank1, 1'b1);
		hit_reset_cs = bm_hit(BUS_REQ.addr, bm_pkg::OFS_RESET_CS, bank1, 1'b0);
	end

	// Plain register decode; absent variant registers never match
	always_comb begin
		for (int i = 0; i < bm_pkg::N_SIMPLE; i++) begin
			simple_hit[i] = bm_hit(BUS_REQ.addr, bm_pkg::SIMPLE_OFS[i], bank1,
				bm_pkg::SIMPLE_MIRROR[i]) && bm_present(i);
			simple_we[i]  = BUS_REQ.wr && simple_hit[i] && !warm;
		end
	end

	// Plain storage; the upper counter byte has no entry here
	for (genvar g = 0; g < bm_pkg::N_SIMPLE; g++) begin : g_reg
		// 28-pin variant stores nothing for ports D and E
		localparam logic [7:0] EFF_MASK = (FORTY_PIN ||
			!(g == bm_pkg::IX_DIR_D || g == bm_pkg::IX_DIR_E)) ?
			bm_pkg::SIMPLE_WMASK[g] : 8'h00;
		bm_field_reg #(
			.POR_VAL  (bm_pkg::SIMPLE_POR[g]),
			.WARM_VAL (bm_pkg::SIMPLE_WARM[g]),
			.KEEP     (bm_pkg::SIMPLE_KEEP[g]),
			.WR_MASK  (EFF_MASK)
		) u_reg (
			.clk   (REF_CLK),
			.rst_n (NRST),
			.warm  (warm),
			.we    (simple_we[g]),
			.wdata (BUS_REQ.wdata),
			.q     (simple_q[g])
		);
	end

	// Live bits from peripherals shown in otherwise read-only positions
	always_comb begin
		live_bits = '0;
		if (FORTY_PIN) begin
			live_bits[bm_pkg::IX_DIR_E][bm_pkg::DE_IN_FULL]  = PERIPH.psp_in_full;
			live_bits[bm_pkg::IX_DIR_E][bm_pkg::DE_OUT_FULL] = PERIPH.psp_out_full;
			live_bits[bm_pkg::IX_DIR_E][bm_pkg::DE_OVERFLOW] = psp_overflow;
		end
		live_bits[bm_pkg::IX_SSPSTATE][bm_pkg::SSP_STATE_W-1:0] = PERIPH.ssp_state;
		live_bits[bm_pkg::IX_TXCTRL][bm_pkg::TX_SHIFT_EMPTY]    = PERIPH.tx_shift_empty;
	end

	// Slave overflow is sticky; a new event beats a software clear
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			psp_overflow <= 1'b0;
		end else if (!FORTY_PIN) begin
			psp_overflow <= 1'b0;
		end else if (warm) begin
			psp_overflow <= 1'b0;
		end else if (PERIPH.psp_overflow) begin
			psp_overflow <= 1'b1;
		end else if (simple_we[bm_pkg::IX_DIR_E] && !BUS_REQ.wdata[bm_pkg::DE_OVERFLOW]) begin
			psp_overflow <= 1'b0;
		end
	end

	// Status: power-up and sleep bits follow the reset cause
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			status <= bm_pkg::STATUS_POR;
		end else if (warm) begin
			// Bank bits clear, arithmetic flags kept
			status <= status & bm_pkg::STATUS_KEEP;
			status[bm_pkg::ST_TO] <= !WATCHDOG_RESET_SOURCE;
			status[bm_pkg::ST_PD] <= 1'b1;
		end else begin
			if (BUS_REQ.wr && hit_status) begin
				status <= (BUS_REQ.wdata & bm_pkg::STATUS_WMASK) |
					(status & ~bm_pkg::STATUS_WMASK);
			end
			// Core events override; software cannot write these two
			if (WATCHDOG_CLEARED) begin
				status[bm_pkg::ST_TO] <= 1'b1;
				status[bm_pkg::ST_PD] <= 1'b1;
			end else if (SLEEP_ENTER) begin
				status[bm_pkg::ST_TO] <= 1'b1;
				status[bm_pkg::ST_PD] <= 1'b0;
			end
		end
	end

	// Interrupt control: event flags win over a write in the same cycle
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			intctrl <= bm_pkg::INTCTRL_POR;
		end else if (warm) begin
			intctrl <= intctrl & bm_pkg::INTCTRL_KEEP;
		end else begin
			if (BUS_REQ.wr && hit_intctrl) begin
				intctrl <= BUS_REQ.wdata | {5'h00, PERIPH.intctrl_events};
			end else begin
				intctrl <= intctrl | {5'h00, PERIPH.intctrl_events};
			end
		end
	end

	// Reset cause: power-on clears both, brown-out clears its own flag, warm resets leave them
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			power_flag <= 1'b0;
			brown_flag <= 1'b0;
		end else if (!warm) begin
			if (BUS_REQ.wr && hit_reset_cs) begin
				power_flag <= BUS_REQ.wdata[bm_pkg::RC_POWER];
				brown_flag <= BUS_REQ.wdata[bm_pkg::RC_BROWN] && !BROWN_OUT_RESET;
			end else if (BROWN_OUT_RESET) begin
				brown_flag <= 1'b0; // Hardware clear wins over the write
			end
		end
	end

	// Program counter: top bits come from the holding register on every write or load
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			pc <= bm_pkg::PC_RESET;
		end else if (warm) begin
			pc <= bm_pkg::PC_RESET;
		end else if (BUS_REQ.wr && hit_pc_low) begin
			pc <= {simple_q[bm_pkg::IX_PCHOLD][bm_pkg::PC_HOLD_W-1:0], BUS_REQ.wdata};
		end else if (PC_LOAD) begin
			pc <= {simple_q[bm_pkg::IX_PCHOLD][bm_pkg::PC_HOLD_W-1:0], PC_NEXT_LOW};
		end
	end

	// Read mux; nothing decodes the upper counter byte
	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < bm_pkg::N_SIMPLE; i++) begin
			if (simple_hit[i]) begin
				rd_mux = simple_q[i] | live_bits[i] | bm_pkg::SIMPLE_ONES[i];
			end
		end
		if (hit_indirect) begin
			rd_mux = IND_RDATA;
		end else if (hit_pc_low) begin
			rd_mux = pc[7:0];
		end else if (hit_status) begin
			rd_mux = status;
		end else if (hit_intctrl) begin
			rd_mux = intctrl;
		end else if (hit_reset_cs) begin
			rd_mux = {6'h00, power_flag, brown_flag};
		end
	end

	// Read data registered; held between reads
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 8'h00;
		end else if (BUS_REQ.rd) begin
			RDATA <= rd_mux;
		end
	end

	// Window writes go out one cycle later as a memory write pulse
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			IND_WE    <= 1'b0;
			IND_WDATA <= 8'h00;
		end else begin
			IND_WE <= BUS_REQ.wr && hit_indirect && !warm;
			if (BUS_REQ.wr && hit_indirect) begin
				IND_WDATA <= BUS_REQ.wdata;
			end
		end
	end

	// Warm reset shown to the rest of the chip
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			WARM_RESET <= 1'b0;
		end else begin
			WARM_RESET <= warm;
		end
	end

	// Outputs taken directly from storage
	assign PROGRAM_COUNTER     = pc;
	assign IND_ADDR            = simple_q[bm_pkg::IX_POINTER];
	assign CONFIG.simple       = simple_q;
	assign CONFIG.status       = status;
	assign CONFIG.intctrl      = intctrl;
	assign CONFIG.reset_cause  = {power_flag, brown_flag};

endmodule : bm_bank1_regs
`default_nettype wire

// >>> test/bm_checker.sv
// Port-level checker for the bank-1 register map, bound to the top module.
// Assumes one clock REF_CLK and the asynchronous active-low reset NRST.
`timescale 1ns/1ps
`default_nettype none
module bm_checker (
	input  wire logic                    REF_CLK,
	input  wire logic                    NRST,
	input  wire bm_pkg::bm_bus_req_t     BUS_REQ,
	input  wire logic [7:0]              RDATA,
	input  wire logic                    MASTER_CLEAR_PIN_N,
	input  wire logic                    WATCHDOG_RESET_SOURCE,
	input  wire logic                    PC_LOAD,
	input  wire logic [7:0]              PC_NEXT_LOW,
	input  wire logic [bm_pkg::PC_W-1:0] PROGRAM_COUNTER,
	input  wire logic [7:0]              IND_ADDR,
	input  wire logic                    IND_WE,
	input  wire logic [7:0]              IND_WDATA,
	input  wire bm_pkg::bm_cfg_t         CONFIG,
	input  wire logic                    WARM_RESET
);
	logic [2:0] quiet_cnt; // Cycles since warm sources went idle
	logic       quiet;     // Warm reset fully drained
	logic       win_wr;    // Write to the indirect window
	logic       gap_acc;   // Address with nothing behind it
	// Synchroniser latency means writes are only judged a few edges after warm reset
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			quiet_cnt <= 3'h0;
		end else if (WATCHDOG_RESET_SOURCE || !MASTER_CLEAR_PIN_N) begin
			quiet_cnt <= 3'h0;
		end else if (quiet_cnt != 3'h4) begin
			quiet_cnt <= quiet_cnt + 3'h1;
		end
	end
	// A watchdog request acts in its own cycle, so it must be idle too
	assign quiet   = (quiet_cnt == 3'h4) && !WARM_RESET && !WATCHDOG_RESET_SOURCE;
	assign win_wr  = BUS_REQ.wr && (BUS_REQ.addr == 7'h00);
	assign gap_acc = BUS_REQ.addr inside {[7'h0f:7'h11], [7'h15:7'h17], [7'h1a:7'h1e]};
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	chk_win_strobe: assert property (quiet && win_wr |=> IND_WE)
		else $error("window write gave no memory strobe");
	chk_win_cause: assert property (IND_WE |-> $past(win_wr))
		else $error("memory strobe without window write");
	chk_win_data: assert property (quiet && win_wr |=> IND_WDATA == $past(BUS_REQ.wdata))
		else $error("window write data lost");
	chk_win_addr: assert property (quiet && BUS_REQ.wr && BUS_REQ.addr == 7'h04
		|=> IND_ADDR == $past(BUS_REQ.wdata))
		else $error("memory address does not follow pointer write");
	chk_pc_low: assert property (quiet && PC_LOAD && !(BUS_REQ.wr && BUS_REQ.addr == 7'h02)
		|=> PROGRAM_COUNTER[7:0] == $past(PC_NEXT_LOW))
		else $error("counter low byte not loaded");
	chk_pc_high: assert property (quiet && (PC_LOAD || (BUS_REQ.wr && BUS_REQ.addr == 7'h02))
		|=> PROGRAM_COUNTER[12:8] == $past(CONFIG.simple[bm_pkg::IX_PCHOLD][4:0]))
		else $error("counter top not taken from holding register");
	chk_gap_zero: assert property (BUS_REQ.rd && gap_acc |=> RDATA == 8'h00)
		else $error("empty location read nonzero");
	chk_gap_hold: assert property (quiet && BUS_REQ.wr && gap_acc |=>
		$stable(CONFIG.simple[bm_pkg::IX_T2PER]) && $stable(CONFIG.simple[bm_pkg::IX_OPTION]))
		else $error("write to empty location changed a register");
	chk_spare_bits: assert property (CONFIG.simple[bm_pkg::IX_PERIPHERAL_IRQ_ENABLE_2][7:1] == 7'h00
		&& CONFIG.simple[bm_pkg::IX_PCHOLD][7:5] == 3'h0
		&& CONFIG.simple[bm_pkg::IX_ANALOG][7:3] == 5'h00)
		else $error("unimplemented bit holds a one");
	// Main scenarios reached
	cov_win_wr: cover property (win_wr);
	cov_pc_load: cover property (PC_LOAD);
	cov_warm: cover property ($rose(WARM_RESET));
endmodule : bm_checker
bind bm_bank1_regs bm_checker u_chk (
	.REF_CLK(REF_CLK), .NRST(NRST), .BUS_REQ(BUS_REQ), .RDATA(RDATA),
	.MASTER_CLEAR_PIN_N(MASTER_CLEAR_PIN_N), .WATCHDOG_RESET_SOURCE(WATCHDOG_RESET_SOURCE),
	.PC_LOAD(PC_LOAD), .PC_NEXT_LOW(PC_NEXT_LOW), .PROGRAM_COUNTER(PROGRAM_COUNTER),
	.IND_ADDR(IND_ADDR), .IND_WE(IND_WE), .IND_WDATA(IND_WDATA), .CONFIG(CONFIG),
	.WARM_RESET(WARM_RESET));
`default_nettype wire

// >>> test/bm_mem_model.sv
// Data memory behind the indirect window.
// Assumes address and strobe come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module bm_mem_model (
	input  wire logic       clk,
	input  wire logic [7:0] addr,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] rdata
);
	logic [7:0] mem [256]; // Byte store
	// Scrambled start contents so a stale value never looks right
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end
	assign rdata = mem[addr];
	// Write on the strobe edge
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end
endmodule : bm_mem_model
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the bank-1 register map, both pin variants.
// Assumes the memory model answers the window combinationally.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic REF_CLK = 1'b0;
	logic NRST = 1'b0;
	bm_pkg::bm_bus_req_t req = '0;   // Core request
	bm_pkg::bm_periph_t  per = '0;   // Peripheral status, idle
	logic master_clear_pin_n = 1'b1, wdt = 1'b0, bor = 1'b0, slp = 1'b0, wdc = 1'b0, pc_ld = 1'b0;
	logic [7:0] pc_nl = 8'h00;       // Next counter low byte
	logic [7:0] rdata, rdata28, ind_addr, ind_rdata, ind_wdata;
	logic [12:0] pc;
	logic ind_we, warm_o;            // Memory strobe, warm reset out
	int error_cnt = 0;
	int n_tests = 0;
	// Register offsets, reset values and read-back after writing all ones, 7f at offset 0c
	logic [6:0] ofs [15] = '{7'h01, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0c, 7'h0d,
		7'h0e, 7'h12, 7'h13, 7'h14, 7'h18, 7'h19, 7'h1f};
	logic [7:0] rst_v [15] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00, 8'h00,
		8'h00, 8'hff, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
	logic [7:0] msk_v [15] = '{8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h17, 8'h7f, 8'h01,
		8'h03, 8'hff, 8'hff, 8'hc0, 8'hf7, 8'hff, 8'h07};
	logic [6:0] gap [11] = '{7'h0f, 7'h10, 7'h11, 7'h15, 7'h16, 7'h17, 7'h1a, 7'h1b,
		7'h1c, 7'h1d, 7'h1e};
	always #2.5 REF_CLK = ~REF_CLK;
	bm_bank1_regs #(.FORTY_PIN(1'b1)) dut (
		.REF_CLK(REF_CLK), .NRST(NRST), .BUS_REQ(req), .RDATA(rdata),
		.MASTER_CLEAR_PIN_N(master_clear_pin_n), .WATCHDOG_RESET_SOURCE(wdt), .BROWN_OUT_RESET(bor),
		.SLEEP_ENTER(slp), .WATCHDOG_CLEARED(wdc), .PC_LOAD(pc_ld), .PC_NEXT_LOW(pc_nl),
		.PROGRAM_COUNTER(pc), .IND_ADDR(ind_addr), .IND_RDATA(ind_rdata), .IND_WE(ind_we),
		.IND_WDATA(ind_wdata), .PERIPH(per), .CONFIG(), .WARM_RESET(warm_o));
	// Reduced-pin variant shares every input
	bm_bank1_regs #(.FORTY_PIN(1'b0)) dut28 (
		.REF_CLK(REF_CLK), .NRST(NRST), .BUS_REQ(req), .RDATA(rdata28),
		.MASTER_CLEAR_PIN_N(master_clear_pin_n), .WATCHDOG_RESET_SOURCE(wdt), .BROWN_OUT_RESET(bor),
		.SLEEP_ENTER(slp), .WATCHDOG_CLEARED(wdc), .PC_LOAD(pc_ld), .PC_NEXT_LOW(pc_nl),
		.PROGRAM_COUNTER(), .IND_ADDR(), .IND_RDATA(ind_rdata), .IND_WE(), .IND_WDATA(),
		.PERIPH(per), .CONFIG(), .WARM_RESET());
	bm_mem_model mem (.clk(REF_CLK), .addr(ind_addr), .we(ind_we), .wdata(ind_wdata),
		.rdata(ind_rdata));
	// One compare for every value kind; widths up to the counter
	task automatic chk_val(input string nm, input logic [12:0] e, input logic [12:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk_val
	// One access: request held for one edge, then dropped a cycle later
	task automatic acc(input logic r, input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		#1 req = '{rd: r, wr: w, addr: a, wdata: d};
		@(posedge REF_CLK);
		#1 req = '0;
	endtask : acc
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		acc(1'b0, 1'b1, a, d);
	endtask : wr_reg
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
		acc(1'b1, 1'b0, a, 8'h00);
		chk_val($sformatf("register %h", a), 13'(e), 13'(rdata));
	endtask : rd_reg
	// Holds a side input for a few cycles; 1 = watchdog, 2 = master clear, 3 = brown-out
	task automatic hold_in(input int which, input int n);
		@(posedge REF_CLK);
		#1 {wdt, master_clear_pin_n, bor} = {which == 1, which != 2, which == 3};
		repeat (n) @(posedge REF_CLK);
		#1 {wdt, master_clear_pin_n, bor} = 3'b010;
		chk_val("warm reset out", 13'(which != 3), 13'(warm_o));
		repeat (6) @(posedge REF_CLK);
	endtask : hold_in
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		results();
	end
	// Test sequence
	initial begin
		per.tx_shift_empty = 1'b1;
		repeat (16) @(posedge REF_CLK);
		#1 NRST = 1'b1;
		rd_reg(7'h03, 8'h18);
		wr_reg(7'h03, 8'h20);
		rd_reg(7'h03, 8'h38);
		foreach (ofs[i]) rd_reg(ofs[i], rst_v[i]);
		foreach (gap[i]) rd_reg(gap[i], 8'h00);
		$display("test reset values done");
		// Parallel slave enable stays clear, as the reduced variant needs
		foreach (ofs[i]) wr_reg(ofs[i], (i == 6) ? 8'h7f : 8'hff);
		foreach (gap[i]) wr_reg(gap[i], 8'hff);
		foreach (ofs[i]) rd_reg(ofs[i], msk_v[i]);
		foreach (gap[i]) rd_reg(gap[i], 8'h00);
		hold_in(3, 1);
		rd_reg(7'h0e, 8'h02);
		$display("test write masks done");
		wr_reg(7'h04, 8'h40);
		wr_reg(7'h00, 8'ha5);
		rd_reg(7'h00, 8'ha5);
		wr_reg(7'h04, 8'h41);
		rd_reg(7'h00, 8'h41 ^ 8'h5a);
		chk_val("memory address", 13'h0041, 13'(ind_addr));
		$display("test indirect window done");
		wr_reg(7'h0a, 8'hff);
		rd_reg(7'h0a, 8'h1f);
		@(posedge REF_CLK);
		#1 {pc_ld, pc_nl} = {1'b1, 8'h34};
		@(posedge REF_CLK);
		#1 pc_ld = 1'b0;
		chk_val("program counter", 13'h1f34, pc);
		wr_reg(7'h02, 8'h12);
		chk_val("program counter", 13'h1f12, pc);
		rd_reg(7'h02, 8'h12);
		$display("test program counter done");
		for (int a = 8; a < 10; a++) begin
			rd_reg(7'(a), msk_v[a - 4]);
			chk_val("reduced variant read", 13'h0000, 13'(rdata28));
		end
		$display("test reduced variant done");
		@(posedge REF_CLK);
		#1 slp = 1'b1;
		@(posedge REF_CLK);
		#1 slp = 1'b0;
		rd_reg(7'h03, 8'h30);
		@(posedge REF_CLK);
		#1 wdc = 1'b1;
		@(posedge REF_CLK);
		#1 wdc = 1'b0;
		rd_reg(7'h03, 8'h38);
		$display("test sleep flags done");
		// Event flags land even when a write hits the same cycle
		per.intctrl_events = 3'h4;
		wr_reg(7'h0b, 8'h10);
		per.intctrl_events = 3'h0;
		rd_reg(7'h0b, 8'h14);
		// Sticky slave overflow, cleared by writing zero to its bit
		{per.psp_in_full, per.psp_overflow} = 2'b11;
		rd_reg(7'h09, 8'hb7);
		per.psp_overflow = 1'b0;
		wr_reg(7'h09, 8'h17);
		rd_reg(7'h09, 8'h97);
		per.psp_in_full = 1'b0;
		$display("test event flags done");
		wr_reg(7'h04, 8'h55);
		wr_reg(7'h0b, 8'h81);
		wr_reg(7'h03, 8'h27);
		hold_in(1, 3);
		rd_reg(7'h03, 8'h0f);
		rd_reg(7'h04, 8'h55);
		rd_reg(7'h0b, 8'h01);
		rd_reg(7'h0a, 8'h00);
		rd_reg(7'h01, 8'h00);
		wr_reg(7'h03, 8'h27);
		foreach (ofs[i]) rd_reg(ofs[i], (i == 8) ? 8'h02 : rst_v[i]);
		hold_in(2, 3);
		rd_reg(7'h03, 8'h1f);
		rd_reg(7'h0b, 8'h01);
		$display("test warm resets done");
		results();
	end
endmodule : tb_top
`default_nettype wire
